// *** core/l2key_extract.sv ***
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "l2key_cfg.svh"
// Functional notes
// - selector 0: mask bit per physical port
// - selector 1: mask bit for loopback port
// - selector 2: mask bit for masqueraded port
// - selector 3: bits 0-3 flag CPU/virtual sources
// - selector 3: source port, pipeline point, action
// - group flag from destination MAC bit 40
// - broadcast flag when destination all ones
// - outer tag kind three-bit code set
// - outer tag fields frame or classified
// - outer VLAN zero when untagged
// - second tag kind, zero when absent
// - second tag fields straight from frame
// - third tag kind, zero when absent
// - third tag fields copied from frame
// - both MAC addresses copied whole
// - IPv4 group flag on top nibble E
// - IPv6 group flag on top byte FF
// - type flag when type field >= 0x600
// - selector takes highest applicable mode
module l2key_extract #(
	parameter logic [2:0] INJ_MASQ_ACT = 3'h1
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire l2key_pkg::frame_t i_frame,
	input wire logic [`REG_AW-1:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output l2key_pkg::key_t o_key,
	output logic o_key_valid,
	output logic [31:0] o_reg_rdata
);
	import l2key_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [`CTRL_W-1:0] ctrl_reg;
	logic [2:0][15:0] custom_tpid_reg;
	logic [1:0] last_sel_reg;
	logic [15:0] key_cnt_reg;
	logic [31:0] rd_next;
	logic use_cl;
	logic is_lbk;
	logic is_cpu;
	logic is_vd;
	logic is_masq;
	logic [1:0] sel_next;
	logic [`MASK_W-1:0] mask_next;
	key_tag_t [2:0] tag_out;
	key_t key_next;

	// custom identifier slot for an address, 3 when none
	function automatic logic [1:0] cust_slot(input logic [`REG_AW-1:0] a);
		logic [1:0] s;
		case (a)
			`REG_CUST1: s = 2'h0;
			`REG_CUST2: s = 2'h1;
			`REG_CUST3: s = 2'h2;
			default: s = 2'h3;
		endcase
		return s;
	endfunction : cust_slot

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			ctrl_reg <= `CTRL_RST;
		end else if (i_reg_wr && i_reg_addr == `REG_CTRL) begin
			ctrl_reg <= i_reg_wdata[`CTRL_W-1:0];
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_cust
			always_ff @(posedge i_clk_sys) begin
				if (i_reset) begin
					custom_tpid_reg[g] <= `CUST_RST;
				end else if (i_reg_wr && cust_slot(i_reg_addr) == 2'(g)) begin
					custom_tpid_reg[g] <= i_reg_wdata[15:0];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// register reads
	// ----------------------------------------
	always_comb begin
		rd_next = '0;
		case (i_reg_addr)
			`REG_CTRL: rd_next[`CTRL_W-1:0] = ctrl_reg;
			`REG_STATUS: begin
				rd_next[1:0] = last_sel_reg;
				rd_next[`ST_CNT_LSB +: 16] = key_cnt_reg;
			end
			default: begin
				if (cust_slot(i_reg_addr) != 2'h3) begin
					rd_next[15:0] = custom_tpid_reg[cust_slot(i_reg_addr)];
				end
			end
		endcase
	end

	// read data stand for one cycle only
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_reg_rdata <= '0;
		end else begin
			o_reg_rdata <= i_reg_rd ? rd_next : '0;
		end
	end

	// ----------------------------------------
	// source mask selector
	// ----------------------------------------
	assign use_cl = ctrl_reg[`CTRL_USE_CL];
	assign is_lbk = (i_frame.src_kind == SRC_LBK);
	assign is_cpu = (i_frame.src_kind == SRC_CPU_PORT_ZERO) ||
		(i_frame.src_kind == SRC_CPU_PORT_ONE);
	assign is_vd = (i_frame.src_kind == SRC_VD0) ||
		(i_frame.src_kind == SRC_VD1);
	assign is_masq = (i_frame.inject &&
		i_frame.ifh_src_port != i_frame.phys_port) ||
		(i_frame.pipe_act == INJ_MASQ_ACT);

	always_comb begin
		sel_next = `SEL_PHYS;
		if ((is_cpu && ctrl_reg[`CTRL_CPU_EN]) ||
				(is_vd && ctrl_reg[`CTRL_VD_EN]) ||
				(is_lbk && ctrl_reg[`CTRL_LBK3_EN])) begin
			sel_next = `SEL_SPECIAL;
		end else if (is_masq && ctrl_reg[`CTRL_MASQ_EN]) begin
			sel_next = `SEL_MASQ;
		end else if (is_lbk) begin
			sel_next = `SEL_LOOP;
		end
	end

	src_mask_build u_mask (
		.i_sel(sel_next),
		.i_kind(i_frame.src_kind),
		.i_phys_port(i_frame.phys_port),
		.i_loop_port(i_frame.loop_port),
		.i_src_port(i_frame.ifh_src_port),
		.i_masq(is_masq),
		.i_pipe_pt(i_frame.pipe_pt),
		.i_pipe_act(i_frame.pipe_act),
		.o_mask(mask_next)
	);

	// ----------------------------------------
	// tag decoding
	// ----------------------------------------
	generate
		for (g = 0; g < 3; g++) begin : g_tag
			tag_field_pick u_tag (
				.i_tag(i_frame.tags[g]),
				.i_custom_tpid(custom_tpid_reg),
				.o_tag(tag_out[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// key assembly
	// ----------------------------------------
	always_comb begin
		key_next = '0;
		key_next.source_mask_selector = sel_next;
		key_next.ingress_source_mask = mask_next;
		key_next.dest_group_flag = i_frame.dmac[`DMAC_GROUP_BIT];
		key_next.dest_all_ones_flag = &i_frame.dmac;
		key_next.outer_tag_kind = tag_out[0].kind;
		key_next.outer_priority_code =
			use_cl ? i_frame.cl_pcp : tag_out[0].pcp;
		key_next.outer_drop_eligible =
			use_cl ? i_frame.cl_dei : tag_out[0].dei;
		if (tag_out[0].kind != `KIND_NONE) begin
			key_next.outer_vlan_id =
				use_cl ? i_frame.cl_vid : tag_out[0].vid;
		end
		key_next.second_tag_kind = tag_out[1].kind;
		key_next.second_priority_code = tag_out[1].pcp;
		key_next.second_drop_eligible = tag_out[1].dei;
		key_next.second_vlan_id = tag_out[1].vid;
		key_next.third_tag_kind = tag_out[2].kind;
		key_next.third_priority_code = tag_out[2].pcp;
		key_next.third_drop_eligible = tag_out[2].dei;
		key_next.third_vlan_id = tag_out[2].vid;
		key_next.dest_mac_field = i_frame.dmac;
		key_next.src_mac_field = i_frame.smac;
		key_next.ip_group_flag =
			(i_frame.is_ipv4 &&
			i_frame.dip_top[7:4] == `IP4_MC_NIB) ||
			(i_frame.is_ipv6 && i_frame.dip_top == `IP6_MC_BYTE);
		key_next.type_encoded_flag =
			(i_frame.type_len >= `TYPE_MIN);
	end

	// ----------------------------------------
	// key output and status
	// ----------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_key <= '0;
		end else if (i_frame.valid) begin
			o_key <= key_next;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_key_valid <= 1'b0;
		end else begin
			o_key_valid <= i_frame.valid;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			last_sel_reg <= `SEL_PHYS;
			key_cnt_reg <= '0;
		end else if (i_frame.valid) begin
			last_sel_reg <= sel_next;
			key_cnt_reg <= key_cnt_reg + 16'h0001;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_reset);

	chk_mask_phys: assert property (
		i_frame.valid && sel_next == `SEL_PHYS &&
		i_frame.phys_port < 6'h34
		|=> o_key.ingress_source_mask ==
		(`MASK_W'(1) << $past(i_frame.phys_port)))
		else $error("physical port mask wrong");

	// a masqueraded loopback frame outranks mode 1 when CTRL_MASQ_EN is set; top ports give no bit
	chk_mask_loop: assert property (
		i_frame.valid && is_lbk && !ctrl_reg[`CTRL_LBK3_EN] &&
		!(is_masq && ctrl_reg[`CTRL_MASQ_EN]) &&
		i_frame.loop_port < 6'h34
		|=> o_key.source_mask_selector == `SEL_LOOP &&
		o_key.ingress_source_mask[$past(i_frame.loop_port)])
		else $error("loopback port mask wrong");

	chk_mask_masq: assert property (
		i_frame.valid && sel_next == `SEL_MASQ &&
		i_frame.ifh_src_port < 6'h34
		|=> o_key.ingress_source_mask[$past(i_frame.ifh_src_port)] &&
		$onehot(o_key.ingress_source_mask))
		else $error("masquerade port mask wrong");

	chk_cpu_flag: assert property (
		i_frame.valid && sel_next == `SEL_SPECIAL &&
		i_frame.src_kind == SRC_CPU_PORT_ONE
		|=> o_key.ingress_source_mask[3:0] == 4'h2)
		else $error("cpu source flag wrong");

	chk_special_fields: assert property (
		i_frame.valid && sel_next == `SEL_SPECIAL
		|=> o_key.ingress_source_mask[51:49] == $past(i_frame.pipe_act)
		&& o_key.ingress_source_mask[48:44] == $past(i_frame.pipe_pt))
		else $error("pipeline fields wrong");

	chk_group_flag: assert property (
		i_frame.valid
		|=> o_key.dest_group_flag == $past(i_frame.dmac[40]))
		else $error("group flag wrong");

	chk_bcast_flag: assert property (
		i_frame.valid
		|=> o_key.dest_all_ones_flag ==
		($past(i_frame.dmac) == 48'hFFFF_FFFF_FFFF))
		else $error("broadcast flag wrong");

	chk_outer_ctag: assert property (
		i_frame.valid && i_frame.tags[0].present &&
		i_frame.tags[0].tpid == 16'h8100
		|=> o_key.outer_tag_kind == 3'h1)
		else $error("outer tag kind wrong");

	chk_outer_class: assert property (
		i_frame.valid && use_cl && tag_out[0].kind != `KIND_NONE
		|=> o_key.outer_vlan_id == $past(i_frame.cl_vid) &&
		o_key.outer_priority_code == $past(i_frame.cl_pcp))
		else $error("classified outer fields not used");

	chk_untag_vid: assert property (
		o_key_valid && o_key.outer_tag_kind == 3'h0
		|-> o_key.outer_vlan_id == 12'h000)
		else $error("untagged vlan id not zero");

	chk_second_absent: assert property (
		i_frame.valid && !i_frame.tags[1].present
		|=> o_key.second_tag_kind == 3'h0 &&
		o_key.second_vlan_id == 12'h000)
		else $error("absent second tag not zero");

	chk_third_copy: assert property (
		i_frame.valid && tag_out[2].kind != `KIND_NONE
		|=> o_key.third_vlan_id == $past(i_frame.tags[2].vid))
		else $error("third vlan id not copied");

	chk_mac_copy: assert property (
		i_frame.valid
		|=> o_key.src_mac_field == $past(i_frame.smac) &&
		o_key.dest_mac_field == $past(i_frame.dmac))
		else $error("mac fields not copied");

	chk_ip4_group: assert property (
		i_frame.valid && i_frame.is_ipv4 && !i_frame.is_ipv6
		|=> o_key.ip_group_flag == ($past(i_frame.dip_top[7:4]) == 4'hE))
		else $error("ipv4 group flag wrong");

	chk_ip6_group: assert property (
		i_frame.valid && i_frame.is_ipv6 && !i_frame.is_ipv4
		|=> o_key.ip_group_flag == ($past(i_frame.dip_top) == 8'hFF))
		else $error("ipv6 group flag wrong");

	chk_type_flag: assert property (
		i_frame.valid
		|=> o_key.type_encoded_flag == ($past(i_frame.type_len) > 16'h05FF))
		else $error("type flag wrong");

	chk_sel_order: assert property (
		i_frame.valid && is_cpu && ctrl_reg[`CTRL_CPU_EN]
		|=> o_key.source_mask_selector == 2'h3 && last_sel_reg == 2'h3)
		else $error("selector priority wrong");

	chk_mask_top: assert property (
		o_key_valid |-> !o_key.ingress_source_mask[`MASK_RSV_BIT])
		else $error("reserved mask bit set");
endmodule : l2key_extract

// *** core/l2key_cfg.svh ***
`ifndef L2KEY_CFG_SVH
`define L2KEY_CFG_SVH
// ----------------------------------------
// key layout
// ----------------------------------------
`define MASK_W 53
`define PORT_W 6
`define MASK_RSV_BIT 52
`define M3_PORT_LSB 4
`define M3_PT_LSB 44
`define M3_ACT_LSB 49
`define DMAC_GROUP_BIT 40
`define SEL_PHYS 2'h0
`define SEL_LOOP 2'h1
`define SEL_MASQ 2'h2
`define SEL_SPECIAL 2'h3
`define KIND_NONE 3'h0
`define KIND_CTAG 3'h1
`define KIND_STAG 3'h4
`define KIND_CUST1 3'h5
`define TPID_CTAG 16'h8100
`define TPID_STAG 16'h88A8
`define TYPE_MIN 16'h0600
`define IP4_MC_NIB 4'hE
`define IP6_MC_BYTE 8'hFF
// ----------------------------------------
// register map
// ----------------------------------------
`define REG_AW 8
`define REG_CTRL 8'h00
`define REG_CUST1 8'h04
`define REG_CUST2 8'h08
`define REG_CUST3 8'h0C
`define REG_STATUS 8'h10
`define CTRL_W 5
`define CTRL_USE_CL 0
`define CTRL_MASQ_EN 1
`define CTRL_CPU_EN 2
`define CTRL_VD_EN 3
`define CTRL_LBK3_EN 4
`define CTRL_RST 5'h00
`define CUST_RST 16'h0000
`define ST_CNT_LSB 16
`endif

// *** core/l2key_pkg.sv ***
`include "l2key_cfg.svh"
package l2key_pkg;
	typedef enum logic [2:0] {
		SRC_FRONT, SRC_CPU_PORT_ZERO, SRC_CPU_PORT_ONE, SRC_VD0, SRC_VD1, SRC_LBK
	} src_kind_t;

	typedef struct packed {
		logic present;
		logic [15:0] tpid;
		logic [2:0] pcp;
		logic dei;
		logic [11:0] vid;
	} frame_tag_t;

	typedef struct packed {
		logic [2:0] kind;
		logic [2:0] pcp;
		logic dei;
		logic [11:0] vid;
	} key_tag_t;

	typedef struct packed {
		logic valid;
		logic [47:0] dmac;
		logic [47:0] smac;
		frame_tag_t [2:0] tags;
		logic [15:0] type_len;
		logic is_ipv4;
		logic is_ipv6;
		logic [7:0] dip_top;
		src_kind_t src_kind;
		logic [`PORT_W-1:0] phys_port;
		logic [`PORT_W-1:0] loop_port;
		logic [`PORT_W-1:0] ifh_src_port;
		logic inject;
		logic [4:0] pipe_pt;
		logic [2:0] pipe_act;
		logic [2:0] cl_pcp;
		logic cl_dei;
		logic [11:0] cl_vid;
	} frame_t;

	typedef struct packed {
		logic [1:0] source_mask_selector;
		logic [`MASK_W-1:0] ingress_source_mask;
		logic dest_group_flag;
		logic dest_all_ones_flag;
		logic [2:0] outer_tag_kind;
		logic [2:0] outer_priority_code;
		logic outer_drop_eligible;
		logic [11:0] outer_vlan_id;
		logic [2:0] second_tag_kind;
		logic [2:0] second_priority_code;
		logic second_drop_eligible;
		logic [11:0] second_vlan_id;
		logic [2:0] third_tag_kind;
		logic [2:0] third_priority_code;
		logic third_drop_eligible;
		logic [11:0] third_vlan_id;
		logic [47:0] dest_mac_field;
		logic [47:0] src_mac_field;
		logic ip_group_flag;
		logic type_encoded_flag;
	} key_t;
endpackage : l2key_pkg

// *** core/tag_field_pick.sv ***
`timescale 1ns/1ps
`include "l2key_cfg.svh"
module tag_field_pick (
	input wire l2key_pkg::frame_tag_t i_tag,
	input wire logic [2:0][15:0] i_custom_tpid,
	output l2key_pkg::key_tag_t o_tag
);
	import l2key_pkg::*;

	function automatic logic [2:0] kind_of(input logic [15:0] tpid,
			input logic [2:0][15:0] cust);
		logic [2:0] k;
		k = `KIND_NONE;
		if (tpid == `TPID_CTAG) begin
			k = `KIND_CTAG;
		end else if (tpid == `TPID_STAG) begin
			k = `KIND_STAG;
		end else begin
			for (int i = 2; i >= 0; i--) begin
				if (tpid == cust[i]) begin
					k = 3'(`KIND_CUST1 + i);
				end
			end
		end
		return k;
	endfunction : kind_of

	always_comb begin
		logic [2:0] k;
		k = i_tag.present ? kind_of(i_tag.tpid, i_custom_tpid) : `KIND_NONE;
		o_tag = '0;
		o_tag.kind = k;
		if (k != `KIND_NONE) begin
			o_tag.pcp = i_tag.pcp;
			o_tag.dei = i_tag.dei;
			o_tag.vid = i_tag.vid;
		end
	end
endmodule : tag_field_pick

// *** core/src_mask_build.sv ***
`timescale 1ns/1ps
`include "l2key_cfg.svh"
module src_mask_build #(
	parameter int MASK_W = `MASK_W,
	parameter int PORT_W = `PORT_W
) (
	input wire logic [1:0] i_sel,
	input wire l2key_pkg::src_kind_t i_kind,
	input wire logic [PORT_W-1:0] i_phys_port,
	input wire logic [PORT_W-1:0] i_loop_port,
	input wire logic [PORT_W-1:0] i_src_port,
	input wire logic i_masq,
	input wire logic [4:0] i_pipe_pt,
	input wire logic [2:0] i_pipe_act,
	output logic [MASK_W-1:0] o_mask
);
	import l2key_pkg::*;

	// top bit stays clear for any port index
	function automatic logic [MASK_W-1:0] port_bit(input logic [PORT_W-1:0] p);
		logic [MASK_W-1:0] m;
		m = '0;
		if (int'(p) < MASK_W - 1) begin
			m[p] = 1'b1;
		end
		return m;
	endfunction : port_bit

	always_comb begin
		o_mask = '0;
		case (i_sel)
			`SEL_PHYS: o_mask = port_bit(i_phys_port);
			`SEL_LOOP: o_mask = port_bit(i_loop_port);
			`SEL_MASQ: o_mask = port_bit(i_src_port);
			`SEL_SPECIAL: begin
				o_mask[0] = (i_kind == SRC_CPU_PORT_ZERO);
				o_mask[1] = (i_kind == SRC_CPU_PORT_ONE);
				o_mask[2] = (i_kind == SRC_VD0);
				o_mask[3] = (i_kind == SRC_VD1);
				o_mask[`M3_PORT_LSB +: PORT_W] =
					i_masq ? i_src_port : i_phys_port;
				o_mask[`M3_PT_LSB +: 5] = i_pipe_pt;
				o_mask[`M3_ACT_LSB +: 3] = i_pipe_act;
			end
			default: o_mask = '0;
		endcase
	end
endmodule : src_mask_build

// *** verification/key_sink_model.sv ***
`timescale 1ns/1ps
module key_sink_model (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire l2key_pkg::key_t i_key,
	input wire logic i_key_valid,
	output logic [15:0] o_keys_seen,
	output l2key_pkg::key_t o_last_key
);
	import l2key_pkg::*;
	// ----------------------------------------
	// key intake, one entry per valid pulse
	// ----------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_keys_seen <= 16'h0000;
			o_last_key <= '0;
		end else if (i_key_valid) begin
			o_keys_seen <= o_keys_seen + 16'h0001;
			o_last_key <= i_key;
		end
	end
endmodule : key_sink_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`include "l2key_cfg.svh"
module tb_top;
	import l2key_pkg::*;
	logic i_clk_sys;
	logic i_reset;
	frame_t frame;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic rd_d;
	key_t key;
	logic key_valid;
	logic [31:0] rdata;
	logic [15:0] seen;
	key_t kq[$];
	key_t kh;
	logic [31:0] rq[$];
	int n_errors;
	int num_checks;
	int seed;
	int cnt;
	logic [4:0] ctrl;
	logic [1:0] last_sel;
	logic [15:0] cust [3];

	l2key_extract dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.i_frame(frame), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_key(key), .o_key_valid(key_valid),
		.o_reg_rdata(rdata));
	key_sink_model sink (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.i_key(key), .i_key_valid(key_valid), .o_keys_seen(seen),
		.o_last_key());

	// ----------------------------------------
	// reference key
	// ----------------------------------------
	function automatic key_tag_t tagk(frame_tag_t t);
		key_tag_t k;
		k = '0;
		if (t.present) begin
			if (t.tpid == 16'h8100) k.kind = 3'h1;
			else if (t.tpid == 16'h88A8) k.kind = 3'h4;
			else if (t.tpid == cust[0]) k.kind = 3'h5;
			else if (t.tpid == cust[1]) k.kind = 3'h6;
			else if (t.tpid == cust[2]) k.kind = 3'h7;
		end
		if (k.kind != 3'h0) begin
			k.pcp = t.pcp;
			k.dei = t.dei;
			k.vid = t.vid;
		end
		return k;
	endfunction : tagk

	function automatic key_t exp_key(frame_t f);
		key_t k;
		key_tag_t t;
		logic m;
		logic [1:0] s;
		logic [5:0] p;
		k = '0;
		s = 2'h0;
		m = (f.inject && f.ifh_src_port != f.phys_port) ||
			f.pipe_act == 3'h1;
		if (f.src_kind == SRC_LBK) s = 2'h1;
		if (m && ctrl[1]) s = 2'h2;
		if (((f.src_kind == SRC_CPU_PORT_ZERO || f.src_kind == SRC_CPU_PORT_ONE) && ctrl[2]) ||
			((f.src_kind == SRC_VD0 || f.src_kind == SRC_VD1) && ctrl[3]) ||
			(f.src_kind == SRC_LBK && ctrl[4])) s = 2'h3;
		k.source_mask_selector = s;
		p = (s == 2'h0) ? f.phys_port :
			(s == 2'h1) ? f.loop_port : f.ifh_src_port;
		if (s != 2'h3) begin
			if (p < 6'd52) begin
				k.ingress_source_mask[p] = 1'b1;
			end
		end else begin
			k.ingress_source_mask[0] = f.src_kind == SRC_CPU_PORT_ZERO;
			k.ingress_source_mask[1] = f.src_kind == SRC_CPU_PORT_ONE;
			k.ingress_source_mask[2] = f.src_kind == SRC_VD0;
			k.ingress_source_mask[3] = f.src_kind == SRC_VD1;
			k.ingress_source_mask[9:4] =
				m ? f.ifh_src_port : f.phys_port;
			k.ingress_source_mask[48:44] = f.pipe_pt;
			k.ingress_source_mask[51:49] = f.pipe_act;
		end
		k.dest_group_flag = f.dmac[40];
		k.dest_all_ones_flag = &f.dmac;
		t = tagk(f.tags[0]);
		k.outer_tag_kind = t.kind;
		k.outer_priority_code = ctrl[0] ? f.cl_pcp : t.pcp;
		k.outer_drop_eligible = ctrl[0] ? f.cl_dei : t.dei;
		k.outer_vlan_id =
			(ctrl[0] && t.kind != 3'h0) ? f.cl_vid : t.vid;
		t = tagk(f.tags[1]);
		k.second_tag_kind = t.kind;
		k.second_priority_code = t.pcp;
		k.second_drop_eligible = t.dei;
		k.second_vlan_id = t.vid;
		t = tagk(f.tags[2]);
		k.third_tag_kind = t.kind;
		k.third_priority_code = t.pcp;
		k.third_drop_eligible = t.dei;
		k.third_vlan_id = t.vid;
		k.dest_mac_field = f.dmac;
		k.src_mac_field = f.smac;
		k.ip_group_flag = (f.is_ipv4 && f.dip_top[7:4] == 4'hE) ||
			(f.is_ipv6 && f.dip_top == 8'hFF);
		k.type_encoded_flag = f.type_len >= 16'h0600;
		return k;
	endfunction : exp_key

	// ----------------------------------------
	// drivers
	// ----------------------------------------
	task automatic cmp(input logic [255:0] got, input logic [255:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_clk_sys);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clk_sys);
		addr <= a;
		rd <= 1'b1;
		rq.push_back(e);
		@(posedge i_clk_sys);
		rd <= 1'b0;
	endtask : reg_rd

	task automatic send(input int n);
		frame_t f;
		key_t e;
		logic [31:0] r;
		for (int j = 0; j < n; j++) begin
			f = '0;
			r = $random(seed);
			f.valid = 1'b1;
			f.dmac = r[0] ? 48'hFFFFFFFFFFFF : {r[31:16], $random(seed)};
			f.smac = {r[15:0], $random(seed)};
			for (int i = 0; i < 3; i++) begin
				r = $random(seed);
				f.tags[i].present = r[0];
				if (r[0]) begin
					case (r[3:1])
						3'h0: f.tags[i].tpid = 16'h8100;
						3'h1: f.tags[i].tpid = 16'h88A8;
						3'h2, 3'h3, 3'h4: f.tags[i].tpid = cust[r[3:1] - 3'h2];
						default: f.tags[i].tpid = ctrl[0] ? 16'h8100 : 16'h1234;
					endcase
					f.tags[i].pcp = r[6:4];
					f.tags[i].dei = r[7];
					f.tags[i].vid = r[19:8];
				end
			end
			r = $random(seed);
			f.type_len = r[1:0] == 2'h0 ? 16'h05FF : r[1:0] == 2'h1 ? 16'h0600 :
				r[31:16];
			f.is_ipv4 = r[2];
			f.is_ipv6 = r[3];
			f.dip_top = r[4] ? 8'hFF : r[15:8];
			f.src_kind = src_kind_t'(3'(r[18:16] % 3'd6));
			r = $random(seed);
			f.phys_port = r[5:0];
			f.loop_port = r[11:6];
			f.ifh_src_port = r[12] ? r[5:0] : r[18:13];
			f.inject = r[19];
			f.pipe_pt = r[24:20];
			f.pipe_act = r[27:25];
			f.cl_pcp = r[30:28];
			f.cl_dei = r[31];
			r = $random(seed);
			f.cl_vid = r[11:0];
			@(posedge i_clk_sys);
			frame <= f;
			e = exp_key(f);
			kq.push_back(e);
			cnt++;
			last_sel = e.source_mask_selector;
		end
		@(posedge i_clk_sys);
		frame.valid <= 1'b0;
	endtask : send

	task automatic test_done;
		if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	// ----------------------------------------
	// result watcher
	// ----------------------------------------
	// read data stand one cycle only, key held between pulses
	always @(negedge i_clk_sys) begin
		if (rd_d === 1'b1) begin
			cmp(rdata, rq.pop_front());
		end else if (i_reset === 1'b0) begin
			cmp(rdata, 32'h00000000);
		end
		rd_d = rd;
		if (key_valid === 1'b1) begin
			kh = kq.pop_front();
			cmp(key, kh);
		end else if (i_reset === 1'b0) begin
			cmp(key, kh);
		end
	end

	initial begin
		i_clk_sys = 1'b0;
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end

	initial begin
		#50000;
		n_errors++;
		test_done;
	end

	initial begin
		i_reset = 1'b1;
		frame = '0;
		kh = '0;
		addr = 8'h00;
		wdata = 32'h00000000;
		wr = 1'b0;
		rd = 1'b0;
		rd_d = 1'b0;
		seed = 6;
		cnt = 0;
		n_errors = 0;
		num_checks = 0;
		ctrl = 5'h00;
		last_sel = 2'h0;
		cust = '{16'h9100, 16'h9200, 16'h88A9};
		repeat (6) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		for (int i = 0; i < 5; i++) reg_rd(8'(4 * i), 32'h00000000);
		reg_wr(8'h14, 32'hFFFFFFFF);
		reg_rd(8'h14, 32'h00000000);
		for (int i = 0; i < 3; i++) begin
			reg_wr(8'(8'h04 + 4 * i), {16'hFFFF, cust[i]});
			reg_rd(8'(8'h04 + 4 * i), {16'h0000, cust[i]});
		end
		reg_wr(8'h00, 32'hFFFFFFFF);
		reg_rd(8'h00, 32'h0000001F);
		for (int c = 0; c < 32; c++) begin
			ctrl = 5'(c);
			reg_wr(8'h00, {27'h0, ctrl});
			send(24);
		end
		repeat (3) @(posedge i_clk_sys);
		reg_rd(8'h10, {cnt[15:0], 14'h0, last_sel});
		repeat (3) @(posedge i_clk_sys);
		cmp(seen, cnt[15:0]);
		cmp(kq.size(), 0);
		// mid-run reset clears control, identifiers, status and key
		i_reset <= 1'b1;
		kh = '0;
		repeat (2) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		reg_rd(8'h00, 32'h00000000);
		reg_rd(8'h04, 32'h00000000);
		reg_rd(8'h10, 32'h00000000);
		repeat (2) @(posedge i_clk_sys);
		cmp(seen, 16'h0000);
		test_done;
	end
endmodule : tb_top
